// [verilog/pms_cfg.svh]
// Constants of the power-mode and reset sequencer: offsets, fields, resets
// and timing. Assumes a 10 MHz hclk and a 32-bit AHB-Lite register bus.
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH

// Register byte offsets
`define PMS_PLL_CONTROL_OFS 8'h00
`define PMS_POWER_CONTROL_OFS 8'h04
`define PMS_STATUS_OFS 8'h08

// Pll control fields
`define PMS_OSC_PD_BIT 0

// Power control fields
`define PMS_IDLE_BIT 0
`define PMS_PDOWN_BIT 1
`define PMS_TIC_KEEP_BIT 2
`define PMS_SER_WAKE_BIT 3
`define PMS_EXT0_WAKE_BIT 4

// Status fields
`define PMS_ST_MODE_LSB 0
`define PMS_ST_DOWNLOAD_BIT 2
`define PMS_ST_PD_WOKE_BIT 3

// Reset values
`define PMS_PLL_CONTROL_RST 8'h00
`define PMS_POWER_CONTROL_RST 8'h00

// Timing
`define PMS_CLK_HZ 10000000
`define PMS_POR_HOLD_MS 128
`define PMS_POR_HOLD_CYCLES (`PMS_POR_HOLD_MS * (`PMS_CLK_HZ / 1000))

`endif

// [verilog/pms_pkg.sv]
// Types of the power-mode and reset sequencer.
// Assumes pms_cfg.svh for all numeric constants.
package pms_pkg;

	// Operating modes of the chip
	typedef enum logic [1:0] {
		PMS_RESET,
		PMS_RUN,
		PMS_IDLE,
		PMS_PDOWN
	} pms_mode_type;

	// Clock and pad controls driven toward the rest of the chip
	typedef struct packed {
		logic osc_en;
		logic pll_en;
		logic core_clk_en;
		logic periph_clk_en;
		logic tic_clk_en;
		logic port_hold;
		logic dac_hiz;
	} pms_ctrl_type;

	// Wake sources
	typedef struct packed {
		logic any_enabled_irq;
		logic tic_irq;
		logic serial_irq;
		logic ext_irq_zero_n;
	} pms_wake_type;

endpackage

// [verilog/pms_sequencer.sv]
// Power-mode and reset sequencer with its AHB-Lite register slave.
// Assumes synchronous inputs on hclk, supply comparators supplied from
// outside, and a core that honours core_reset and the clock enables.
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "pms_cfg.svh"

module pms_sequencer #(
	parameter int unsigned POR_HOLD_CYCLES = `PMS_POR_HOLD_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic supply_above_release,
	input wire logic supply_above_floor,
	input wire logic ext_reset,
	input wire pms_pkg::pms_wake_type wake,
	input wire logic core_strobe,
	input wire logic program_store_strobe_in,
	output logic program_store_strobe_out,
	output logic program_store_strobe_oe_n,
	output pms_pkg::pms_ctrl_type ctrl,
	output logic core_reset,
	output logic download_mode,
	output logic wake_pulse
);
	import pms_pkg::*;

	if (POR_HOLD_CYCLES < 1)
		$error("POR_HOLD_CYCLES must be at least one");

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	pms_mode_type mode;
	logic [7:0] pll_control_register;
	logic [7:0] power_control_register;
	logic pd_woke;
	logic por_busy;
	logic [31:0] por_count;
	logic hold_reset;
	logic pd_wake;
	logic idle_wake;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic addr_ok;
	logic rd_take;

	// Word read from a register offset
	function automatic logic [31:0] read_word(input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0;
		unique case (a)
			`PMS_PLL_CONTROL_OFS: w[7:0] = pll_control_register;
			`PMS_POWER_CONTROL_OFS: w[7:0] = power_control_register;
			`PMS_STATUS_OFS:
			begin
				w[`PMS_ST_MODE_LSB +: 2] = mode;
				w[`PMS_ST_DOWNLOAD_BIT] = download_mode;
				w[`PMS_ST_PD_WOKE_BIT] = pd_woke;
			end
			default: w = 32'h0;
		endcase
		return w;
	endfunction

	// ---------------------------------------------------------------
	// Reset sources
	// ---------------------------------------------------------------
	// Pin reset or power-on hold keep the core, the mode and the registers in reset; the AHB-Lite slave keeps answering
	assign hold_reset = por_busy | ext_reset;

	// Power-on hold: low supply holds, then a timed release
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			por_busy <= 1'b1;
			por_count <= 32'h0;
		end
		else if (!supply_above_release || !supply_above_floor)
		begin
			// Held until the rail is gone, on the way down as well
			por_busy <= 1'b1;
			por_count <= 32'h0;
		end
		else if (por_busy)
		begin
			if (por_count == POR_HOLD_CYCLES - 1)
				por_busy <= 1'b0;
			por_count <= por_count + 32'h1;
		end
	end

	// Registered core reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			core_reset <= 1'b1;
		else
			core_reset <= hold_reset;
	end

	// ---------------------------------------------------------------
	// Boot selection
	// ---------------------------------------------------------------
	// Strobe sampled only on the release edge of reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			download_mode <= 1'b0;
		else if (core_reset && !hold_reset)
			download_mode <= !program_store_strobe_in;
	end

	// Strobe pad: input during reset, output afterwards
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			program_store_strobe_oe_n <= 1'b1;
			program_store_strobe_out <= 1'b1;
		end
		else
		begin
			program_store_strobe_oe_n <= hold_reset;
			program_store_strobe_out <= core_strobe;
		end
	end

	// ---------------------------------------------------------------
	// Mode sequencing
	// ---------------------------------------------------------------
	// Idle ends on any enabled interrupt
	assign idle_wake = wake.any_enabled_irq;
	// Power-down wake sources; serial and line zero have enables, the tic has none; line zero is trusted
	// to stay high around entry
	assign pd_wake = wake.tic_irq
		| (wake.serial_irq
		& power_control_register[`PMS_SER_WAKE_BIT])
		| (!wake.ext_irq_zero_n
		& power_control_register[`PMS_EXT0_WAKE_BIT]);

	// Mode machine; power-down request wins over idle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mode <= PMS_RESET;
		else if (hold_reset)
			mode <= PMS_RESET;
		else
			unique case (mode)
				PMS_RESET: mode <= PMS_RUN;
				PMS_RUN:
				begin
					if (power_control_register[`PMS_PDOWN_BIT])
						mode <= PMS_PDOWN;
					else if (power_control_register[`PMS_IDLE_BIT])
						mode <= PMS_IDLE;
				end
				PMS_IDLE:
					if (idle_wake)
						mode <= PMS_RUN;
				PMS_PDOWN:
					if (pd_wake)
						mode <= PMS_RUN;
			endcase
	end

	// One-cycle wake pulse lets the core service and resume after entry
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wake_pulse <= 1'b0;
		else
			wake_pulse <= !hold_reset
				&& ((mode == PMS_IDLE && idle_wake)
				|| (mode == PMS_PDOWN && pd_wake));
	end

	// Clock and pad controls registered from the current mode, one cycle behind it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl <= '{osc_en: 1'b1, pll_en: 1'b1, core_clk_en: 1'b0,
				periph_clk_en: 1'b1, tic_clk_en: 1'b1,
				port_hold: 1'b0, dac_hiz: 1'b0};
		else
		begin
			ctrl.core_clk_en <= (mode == PMS_RUN);
			ctrl.pll_en <= (mode != PMS_PDOWN);
			ctrl.osc_en <= !(mode == PMS_PDOWN
				&& pll_control_register[`PMS_OSC_PD_BIT]);
			ctrl.periph_clk_en <= (mode != PMS_PDOWN);
			ctrl.tic_clk_en <= (mode != PMS_PDOWN)
				|| (power_control_register[`PMS_TIC_KEEP_BIT]
				&& !pll_control_register[`PMS_OSC_PD_BIT]);
			ctrl.port_hold <= (mode == PMS_IDLE)
				|| (mode == PMS_PDOWN);
			ctrl.dac_hiz <= (mode == PMS_PDOWN);
		end
	end

	// ---------------------------------------------------------------
	// AHB-Lite slave
	// ---------------------------------------------------------------
	// Address phase accepted on a valid selected transfer
	assign addr_ok = hsel && hready && htrans[1];
	assign rd_take = addr_ok && !hwrite;

	// Zero-wait, always OKAY
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Write address held for the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end
		else
		begin
			wr_pend <= addr_ok && hwrite;
			wr_addr <= haddr;
		end
	end

	// Read data captured at the address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (rd_take)
			hrdata <= read_word(haddr);
	end

	// Pll control register; defaults restored by any hardware reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pll_control_register <= `PMS_PLL_CONTROL_RST;
		else if (hold_reset)
			pll_control_register <= `PMS_PLL_CONTROL_RST;
		else if (wr_pend && wr_addr == `PMS_PLL_CONTROL_OFS)
			pll_control_register <= {7'h0, hwdata[`PMS_OSC_PD_BIT]};
	end

	// Power control register; mode request bits clear on wake
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			power_control_register <= `PMS_POWER_CONTROL_RST;
		else if (hold_reset)
			power_control_register <= `PMS_POWER_CONTROL_RST;
		else if (wr_pend && wr_addr == `PMS_POWER_CONTROL_OFS)
			power_control_register <= {3'h0, hwdata[4:0]};
		else if ((mode == PMS_IDLE && idle_wake)
			|| (mode == PMS_PDOWN && pd_wake))
		begin
			power_control_register[`PMS_IDLE_BIT] <= 1'b0;
			power_control_register[`PMS_PDOWN_BIT] <= 1'b0;
		end
	end

	// Sticky power-down wake flag; write one clears, a new wake wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pd_woke <= 1'b0;
		else if (hold_reset)
			pd_woke <= 1'b0;
		else if (mode == PMS_PDOWN && pd_wake)
			pd_woke <= 1'b1;
		else if (wr_pend && wr_addr == `PMS_STATUS_OFS
			&& hwdata[`PMS_ST_PD_WOKE_BIT])
			pd_woke <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	low_supply_reset_a: assert property (
		!supply_above_release |=> ##1 core_reset)
		else $error("Core reset not held under low supply");
	por_timed_release_a: assert property (
		$fell(por_busy) && !ext_reset
			|-> por_count == POR_HOLD_CYCLES ##1 !core_reset)
		else $error("Power-on release at the wrong count");
	pin_reset_mode_a: assert property (
		ext_reset |=> mode == PMS_RESET
			&& power_control_register == `PMS_POWER_CONTROL_RST)
		else $error("Reset pin did not restore defaults");
	idle_clocks_a: assert property (
		mode == PMS_IDLE |=> !ctrl.core_clk_en && ctrl.osc_en
			&& ctrl.periph_clk_en && ctrl.port_hold)
		else $error("Idle clock controls wrong");
	pdown_clocks_a: assert property (
		mode == PMS_PDOWN |=> !ctrl.pll_en && !ctrl.core_clk_en
			&& !ctrl.periph_clk_en && ctrl.dac_hiz)
		else $error("Power-down clock controls wrong");
	osc_stop_a: assert property (
		mode == PMS_PDOWN && pll_control_register[`PMS_OSC_PD_BIT]
			|=> !ctrl.osc_en && !ctrl.tic_clk_en)
		else $error("Oscillator not stopped in power-down");
	serial_gate_a: assert property (
		mode == PMS_PDOWN && !hold_reset && !wake.tic_irq
			&& wake.ext_irq_zero_n
			&& !power_control_register[`PMS_SER_WAKE_BIT]
			|=> mode == PMS_PDOWN)
		else $error("Power-down left without an enabled wake");
	ext0_wake_a: assert property (
		mode == PMS_PDOWN && !hold_reset && !wake.ext_irq_zero_n
			&& power_control_register[`PMS_EXT0_WAKE_BIT]
			|=> mode == PMS_RUN && wake_pulse)
		else $error("Interrupt zero wake missed");
	boot_sample_a: assert property (
		core_reset && !hold_reset && !program_store_strobe_in
			|=> download_mode ##1 download_mode)
		else $error("Download mode not latched");
	strobe_pad_a: assert property (
		core_reset |-> program_store_strobe_oe_n
			|| $past(hold_reset) == 1'b0)
		else $error("Strobe driven during reset");
	pd_woke_set_a: assert property (
		mode == PMS_PDOWN && pd_wake && !hold_reset |=> pd_woke)
		else $error("Power-down wake flag not set");
	wake_pulse_once_a: assert property (
		wake_pulse |=> !wake_pulse)
		else $error("Wake pulse longer than one cycle");
	idle_keeps_regs_a: assert property (
		mode == PMS_IDLE && !hold_reset && !wr_pend
			|=> $stable(pll_control_register))
		else $error("Register lost its value in idle");
	tic_keep_a: assert property (
		mode == PMS_PDOWN
			&& power_control_register[`PMS_TIC_KEEP_BIT]
			&& !pll_control_register[`PMS_OSC_PD_BIT]
			|=> ctrl.tic_clk_en)
		else $error("Interval counter clock dropped in power-down");
	run_outputs_a: assert property (
		mode == PMS_RUN |=> ctrl.core_clk_en && !ctrl.port_hold
			&& !ctrl.dac_hiz)
		else $error("Run mode clock or pad controls wrong");

	idle_round_c: cover property (
		mode == PMS_RUN ##1 mode == PMS_IDLE ##[1:20] mode == PMS_RUN);
	pdown_tic_c: cover property (
		mode == PMS_PDOWN && wake.tic_irq ##1 mode == PMS_RUN);
	download_c: cover property ($rose(download_mode));
	pin_reset_pd_c: cover property (mode == PMS_PDOWN && ext_reset);

endmodule

// [tb/pms_partner.sv]
// Model of the board around the sequencer: supply comparator, reset pin,
// wake sources and the boot jumper on the program-store strobe pad.
// Assumes the bench raises requests; pins move on the next hclk edge.
`timescale 1ns/10ps

module pms_partner (
	input wire logic hclk,
	input wire logic supply_req,
	input wire logic reset_req,
	input wire logic jumper,
	input wire logic [3:0] irq_req,
	input wire logic strobe_out,
	input wire logic strobe_oe_n,
	output logic supply_above_release,
	output logic ext_reset,
	output pms_pkg::pms_wake_type wake,
	output logic strobe_pad
);
	import pms_pkg::*;

	// Pins follow the requests one edge later, like slow board logic
	always @(posedge hclk)
	begin
		supply_above_release <= supply_req;
		ext_reset <= reset_req;
		wake.any_enabled_irq <= irq_req[0];
		wake.tic_irq <= irq_req[1];
		wake.serial_irq <= irq_req[2];
		// Line only drops on request, never near power-down entry
		wake.ext_irq_zero_n <= ~irq_req[3];
	end

	// Pad: device drives it, else the jumper pulls low, else pulled high
	assign strobe_pad = !strobe_oe_n ? strobe_out : !jumper;
endmodule

// [tb/tb_top.sv]
// Self-checking bench of the power-mode and reset sequencer.
// Assumes pms_partner for the board side and a 10 MHz hclk.
`timescale 1ns/10ps
`include "pms_cfg.svh"

module tb_top;
	import pms_pkg::*;

	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, core_reset, download_mode, wake_pulse;
	logic supply_above_release, ext_reset, strobe_pad, strobe_out, oe_n;
	logic supply_req = 1'b1;
	logic reset_req = 1'b0;
	logic jumper = 1'b0;
	logic core_strobe = 1'b1;
	logic [3:0] irq_req = 4'h0;
	logic [31:0] rv;
	pms_wake_type wake;
	pms_ctrl_type ctrl;
	int fails = 0;
	int checks = 0;

	pms_sequencer #(.POR_HOLD_CYCLES(16)) uut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .supply_above_release(supply_above_release),
		.supply_above_floor(1'b1), .ext_reset(ext_reset), .wake(wake),
		.core_strobe(core_strobe), .program_store_strobe_in(strobe_pad),
		.program_store_strobe_out(strobe_out),
		.program_store_strobe_oe_n(oe_n), .ctrl(ctrl),
		.core_reset(core_reset), .download_mode(download_mode),
		.wake_pulse(wake_pulse));

	pms_partner board (.hclk(hclk), .supply_req(supply_req),
		.reset_req(reset_req), .jumper(jumper), .irq_req(irq_req),
		.strobe_out(strobe_out), .strobe_oe_n(oe_n),
		.supply_above_release(supply_above_release),
		.ext_reset(ext_reset), .wake(wake), .strobe_pad(strobe_pad));

	always #50 hclk = ~hclk;

	// ---------------------------------------------
	// Shared tasks
	// ---------------------------------------------
	task end_sim;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task expect_eq(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: %s got %h", $time, m, got);
		end
	endtask

	// One AHB-Lite single transfer; read data taken at the data edge
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask

	task settle(input int c);
		repeat (c) @(posedge hclk);
		#1;
	endtask

	// Counts edges until the core leaves reset
	task wait_release(input int lo, input int hi, input string m);
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			#1;
			n++;
		end
		while (core_reset !== 1'b0 && n < 60);
		expect_eq(n >= lo && n <= hi, 1, m);
	endtask

	task wait_wake(input string m);
		int k;
		k = 0;
		do
		begin
			@(posedge hclk);
			#1;
			k++;
		end
		while (wake_pulse !== 1'b1 && k < 20);
		expect_eq(wake_pulse, 1, m);
		@(posedge hclk);
		irq_req <= 4'h0;
	endtask

	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	task t_regs;
		ahb(1'b0, `PMS_PLL_CONTROL_OFS, 0);
		expect_eq(rv, `PMS_PLL_CONTROL_RST, "pll reset");
		expect_eq(hresp, 0, "okay response");
		ahb(1'b0, `PMS_POWER_CONTROL_OFS, 0);
		expect_eq(rv, `PMS_POWER_CONTROL_RST, "power reset");
		ahb(1'b1, 8'h0c, 32'hffffffff);
		ahb(1'b0, 8'h0c, 0);
		expect_eq(rv, 0, "unmapped");
		ahb(1'b0, `PMS_STATUS_OFS, 0);
		expect_eq(rv[1:0], 1, "run mode");
	endtask

	task t_idle;
		ahb(1'b1, `PMS_PLL_CONTROL_OFS, 1);
		ahb(1'b1, `PMS_POWER_CONTROL_OFS, 1);
		settle(3);
		expect_eq(ctrl.core_clk_en, 0, "idle core clk");
		expect_eq(ctrl.osc_en, 1, "idle osc");
		expect_eq(ctrl.periph_clk_en, 1, "idle periph");
		ahb(1'b0, `PMS_STATUS_OFS, 0);
		expect_eq(rv[1:0], 2, "idle mode");
		irq_req <= 4'h1;
		wait_wake("idle wake");
		ahb(1'b0, `PMS_STATUS_OFS, 0);
		expect_eq(rv[1:0], 1, "idle left");
		ahb(1'b0, `PMS_PLL_CONTROL_OFS, 0);
		expect_eq(rv, 1, "kept reg");
		ahb(1'b1, `PMS_PLL_CONTROL_OFS, 0);
	endtask

	task t_pdown;
		ahb(1'b1, `PMS_POWER_CONTROL_OFS, 2);
		settle(3);
		expect_eq(ctrl.pll_en, 0, "pd pll");
		expect_eq(ctrl.core_clk_en, 0, "pd core");
		expect_eq(ctrl.periph_clk_en, 0, "pd periph");
		expect_eq(ctrl.tic_clk_en, 0, "pd tic off");
		expect_eq(ctrl.osc_en, 1, "pd osc on");
		expect_eq(ctrl.dac_hiz, 1, "pd dac");
		expect_eq(ctrl.port_hold, 1, "pd ports");
		// Serial and external zero sources without their enables
		for (int s = 2; s < 4; s++)
		begin
			@(posedge hclk);
			irq_req <= 4'h1 << s;
			settle(6);
			ahb(1'b0, `PMS_STATUS_OFS, 0);
			expect_eq(rv[1:0], 3, "disabled wake");
			irq_req <= 4'h0;
		end
		@(posedge hclk);
		irq_req <= 4'h2;
		wait_wake("tic wake");
		ahb(1'b0, `PMS_STATUS_OFS, 0);
		expect_eq(rv[`PMS_ST_PD_WOKE_BIT], 1, "woke flag");
		ahb(1'b1, `PMS_STATUS_OFS, 32'h1 << `PMS_ST_PD_WOKE_BIT);
		ahb(1'b0, `PMS_STATUS_OFS, 0);
		expect_eq(rv[`PMS_ST_PD_WOKE_BIT], 0, "woke cleared");
		// Each source with every enable set and the counter kept
		for (int s = 1; s < 4; s++)
		begin
			ahb(1'b1, `PMS_POWER_CONTROL_OFS, 32'h1e);
			settle(3);
			expect_eq(ctrl.tic_clk_en, 1, "tic kept");
			@(posedge hclk);
			irq_req <= 4'h1 << s;
			wait_wake("pd wake");
			ahb(1'b0, `PMS_STATUS_OFS, 0);
			expect_eq(rv[1:0], 1, "pd left");
		end
		ahb(1'b1, `PMS_PLL_CONTROL_OFS, 1);
		ahb(1'b1, `PMS_POWER_CONTROL_OFS, 6);
		settle(3);
		expect_eq(ctrl.osc_en, 0, "osc stopped");
		@(posedge hclk);
		irq_req <= 4'h2;
		wait_wake("osc off wake");
		ahb(1'b1, `PMS_PLL_CONTROL_OFS, 0);
	endtask

	task t_reset;
		ahb(1'b1, `PMS_POWER_CONTROL_OFS, 32'h18);
		jumper <= 1'b1;
		reset_req <= 1'b1;
		settle(3);
		expect_eq(core_reset, 1, "pin reset");
		expect_eq(oe_n, 1, "strobe released");
		@(posedge hclk);
		reset_req <= 1'b0;
		wait_release(1, 3, "pin release");
		expect_eq(download_mode, 1, "download boot");
		ahb(1'b0, `PMS_POWER_CONTROL_OFS, 0);
		expect_eq(rv, 0, "defaults back");
		ahb(1'b0, `PMS_STATUS_OFS, 0);
		expect_eq(rv[`PMS_ST_DOWNLOAD_BIT], 1, "download status");
		@(posedge hclk);
		supply_req <= 1'b0;
		jumper <= 1'b0;
		settle(4);
		expect_eq(core_reset, 1, "low supply");
		@(posedge hclk);
		supply_req <= 1'b1;
		wait_release(16, 20, "supply release");
		expect_eq(download_mode, 0, "normal boot");
		expect_eq(oe_n, 0, "strobe drives");
		@(posedge hclk);
		core_strobe <= 1'b0;
		settle(2);
		expect_eq(strobe_pad, 0, "strobe follows core");
	endtask

	// ---------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------
	initial
	begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		wait_release(16, 20, "power on");
		expect_eq(download_mode, 0, "first boot");
		t_regs;
		t_idle;
		t_pdown;
		t_reset;
		end_sim;
	end

	initial
	begin
		#(5000 * 100);
		fails++;
		end_sim;
	end
endmodule
